/* File: dv/dbs_host_model.sv */
// Host model: input strobe pair, commands and write beats.
// Assumes the port samples on strobe rising edges only.
`timescale 1ns/1ps
`default_nettype none
module dbs_host_model
    import dbs_pkg::*;
(
    output logic k_clk_o,
    output logic kn_clk_o,
    output logic [DBS_ADDR_W-1:0] addr_o,
    output logic rd_sel_n_o,
    output logic wr_sel_n_o,
    output logic [3:0] bw_n_o,
    output logic [DBS_DATA_W-1:0] wdata_o
);
    logic k_q = 1'b0;

    // Idle state at time zero
    initial begin
        addr_o = '0;
        rd_sel_n_o = 1'b1;
        wr_sel_n_o = 1'b1;
        bw_n_o = 4'hF;
        wdata_o = '0;
    end

    // Free-running strobe, complement in antiphase
    always #6 k_q = ~k_q;
    assign k_clk_o = k_q;
    assign kn_clk_o = ~k_q;

    // One command and its burst; released lines flip so stale values never match
    task automatic xfer(input logic rd, input logic wr, input logic [DBS_ADDR_W-1:0] a,
            input logic [143:0] d, input logic [15:0] bw);
        @(posedge kn_clk_o);
        #1;
        rd_sel_n_o = ~rd;
        wr_sel_n_o = ~wr;
        addr_o = a;
        @(posedge k_clk_o);
        #1;
        rd_sel_n_o = 1'b1;
        wr_sel_n_o = 1'b1;
        addr_o = ~a;
        if (wr) begin
            for (int b = 0; b < 4; b++) begin
                wdata_o = d[b*36 +: 36];
                bw_n_o = bw[b*4 +: 4];
                if (b[0]) begin
                    @(posedge kn_clk_o);
                end else begin
                    @(posedge k_clk_o);
                end
                #1;
            end
            wdata_o = ~wdata_o;
            bw_n_o = ~bw_n_o;
        end
    endtask
endmodule
`default_nettype wire

/* File: dv/dbs_sram_port_props.sv */
// Checker for the burst SRAM port: echoes, valid flag, latency, DLL.
// Assumes it is bound to the port and sees only its pins.
`timescale 1ns/1ps
`default_nettype none
module dbs_sram_port_props
    import dbs_pkg::*;
#(
    parameter int DATA_W = DBS_DATA_W,
    parameter int LOCK_CYCLES = DBS_LOCK_CYCLES
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic k_clk_i,
    input wire logic kn_clk_i,
    input wire logic doff_n_i,
    input wire logic [DBS_ADDR_W-1:0] address_bus_i,
    input wire logic rd_sel_n_i,
    input wire logic wr_sel_n_i,
    input wire logic [DATA_W/DBS_LANE_W-1:0] byte_write_n_i,
    input wire logic [DATA_W-1:0] write_in_bus_i,
    input wire logic [DATA_W-1:0] read_out_bus_o,
    input wire logic read_out_oe_n_o,
    input wire logic output_valid_flag_o,
    input wire logic echo_strobe_true_o,
    input wire logic echo_strobe_comp_o,
    input wire logic dll_locked_o
);
    // Cycles doff_n has stayed high; saturates so it never wraps
    logic [15:0] hi_cnt_q;
    always_ff @(posedge clk_i) begin
        if (!doff_n_i) begin
            hi_cnt_q <= 16'h0000;
        end else if (hi_cnt_q != 16'hFFFF) begin
            hi_cnt_q <= hi_cnt_q + 16'h0001;
        end
    end

    echo_true_a: assert property (@(posedge clk_i) disable iff (reset_i)
        echo_strobe_true_o == k_clk_i) else $error("true echo differs");
    echo_comp_a: assert property (@(posedge clk_i) disable iff (reset_i)
        echo_strobe_comp_o == kn_clk_i) else $error("complement echo differs");
    valid_oe_a: assert property (@(posedge clk_i) disable iff (reset_i)
        output_valid_flag_o == !read_out_oe_n_o) else $error("valid and drive disagree");
    idle_zero_a: assert property (@(posedge clk_i) disable iff (reset_i)
        !output_valid_flag_o |-> read_out_bus_o == '0) else $error("idle bus not zero");
    read_start_a: assert property (@(posedge k_clk_i) disable iff (reset_i)
        !rd_sel_n_i |-> ##[2:3] output_valid_flag_o) else $error("read gave no data");
    no_read_a: assert property (@(posedge k_clk_i) disable iff (reset_i)
        rd_sel_n_i && $past(rd_sel_n_i) && $past(rd_sel_n_i, 2) && $past(rd_sel_n_i, 3)
        && $past(rd_sel_n_i, 4) |-> !output_valid_flag_o) else $error("valid with no read");
    dll_off_a: assert property (@(posedge clk_i) disable iff (reset_i)
        !doff_n_i [*8] ##1 !doff_n_i [*4] |-> !dll_locked_o) else $error("locked while off");
    lock_wait_a: assert property (@(posedge clk_i) disable iff (reset_i)
        $rose(dll_locked_o) |-> hi_cnt_q >= LOCK_CYCLES) else $error("locked too early");
endmodule

bind dbs_sram_port dbs_sram_port_props #(.DATA_W(DATA_W), .LOCK_CYCLES(LOCK_CYCLES))
    dbs_sram_port_props_i (.clk_i(clk_i), .reset_i(reset_i), .k_clk_i(k_clk_i),
    .kn_clk_i(kn_clk_i), .doff_n_i(doff_n_i), .address_bus_i(address_bus_i),
    .rd_sel_n_i(rd_sel_n_i), .wr_sel_n_i(wr_sel_n_i), .byte_write_n_i(byte_write_n_i),
    .write_in_bus_i(write_in_bus_i), .read_out_bus_o(read_out_bus_o),
    .read_out_oe_n_o(read_out_oe_n_o), .output_valid_flag_o(output_valid_flag_o),
    .echo_strobe_true_o(echo_strobe_true_o), .echo_strobe_comp_o(echo_strobe_comp_o),
    .dll_locked_o(dll_locked_o));
`default_nettype wire

/* File: dv/dbs_sram_port_test.sv */
// Self-checking bench: random bursts in bypass and DLL mode.
// Assumes the host model drives the link, the bench the system side.
`timescale 1ns/1ps
`default_nettype none
module dbs_sram_port_test
    import dbs_pkg::*;
;
    localparam int LOCK = 16;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic doff_n_i = 1'b0;
    wire logic k_clk_i, kn_clk_i, rd_sel_n_i, wr_sel_n_i;
    wire logic [DBS_ADDR_W-1:0] address_bus_i;
    wire logic [3:0] byte_write_n_i;
    wire logic [35:0] write_in_bus_i;
    logic [35:0] read_out_bus_o;
    logic read_out_oe_n_o, output_valid_flag_o, echo_strobe_true_o, echo_strobe_comp_o;
    logic dll_locked_o;
    logic [35:0] mem [logic [18:0]];
    logic [31:0] seed = 32'h00007DC4;
    int failures = 0;
    int tests_run = 0;
    int n;

    always #5 clk_i = ~clk_i;

    dbs_host_model dbs_host_model_i (.k_clk_o(k_clk_i), .kn_clk_o(kn_clk_i),
        .addr_o(address_bus_i), .rd_sel_n_o(rd_sel_n_i), .wr_sel_n_o(wr_sel_n_i),
        .bw_n_o(byte_write_n_i), .wdata_o(write_in_bus_i));
    dbs_sram_port #(.LOCK_CYCLES(LOCK)) dbs_sram_port_i (.clk_i(clk_i), .reset_i(reset_i),
        .k_clk_i(k_clk_i), .kn_clk_i(kn_clk_i), .doff_n_i(doff_n_i),
        .address_bus_i(address_bus_i), .rd_sel_n_i(rd_sel_n_i), .wr_sel_n_i(wr_sel_n_i),
        .byte_write_n_i(byte_write_n_i), .write_in_bus_i(write_in_bus_i),
        .read_out_bus_o(read_out_bus_o), .read_out_oe_n_o(read_out_oe_n_o),
        .output_valid_flag_o(output_valid_flag_o), .echo_strobe_true_o(echo_strobe_true_o),
        .echo_strobe_comp_o(echo_strobe_comp_o), .dll_locked_o(dll_locked_o));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h00400007 : 32'h00000000);
    endfunction

    // Expected word after a masked write; low select enables a lane
    function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] w,
            input logic [3:0] bw_n);
        logic [35:0] r;
        r = o;
        for (int l = 0; l < 4; l++) begin
            if (!bw_n[l]) begin
                r[l*9 +: 9] = w[l*9 +: 9];
            end
        end
        return r;
    endfunction

    task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Full write defines every lane first, so later masked writes have a known base
    task automatic write_burst(input logic [16:0] a, input logic full);
        logic [143:0] d;
        logic [15:0] bw;
        for (int b = 0; b < 4; b++) begin
            seed = lfsr(seed);
            d[b*36 +: 32] = seed;
            seed = lfsr(seed);
            d[b*36+32 +: 4] = seed[3:0];
            bw[b*4 +: 4] = full ? 4'h0 : seed[7:4];
            if (full) begin
                mem[{a, b[1:0]}] = d[b*36 +: 36];
            end else begin
                mem[{a, b[1:0]}] = merge(mem[{a, b[1:0]}], d[b*36 +: 36], bw[b*4 +: 4]);
            end
        end
        dbs_host_model_i.xfer(1'b0, 1'b1, a, d, bw);
    endtask

    // Beats sampled mid half-cycle, after the output mux has settled
    task automatic read_burst(input logic [16:0] a, input int lat);
        dbs_host_model_i.xfer(1'b1, 1'b0, a, 144'h0, 16'hFFFF);
        repeat (lat) @(posedge k_clk_i);
        for (int b = 0; b < 4; b++) begin
            if (b[0]) begin
                @(posedge k_clk_i);
            end else begin
                @(posedge kn_clk_i);
            end
            #3;
            check("read_beat", read_out_bus_o, mem[{a, b[1:0]}]);
            check("valid_beat", {35'h0, output_valid_flag_o}, 36'h1);
        end
        @(posedge kn_clk_i);
        #3;
        check("idle_oe_n", {35'h0, read_out_oe_n_o}, 36'h1);
        check("idle_valid", {35'h0, output_valid_flag_o}, 36'h0);
    endtask

    task automatic run_bursts(input int cnt, input int lat);
        logic [16:0] a;
        for (int i = 0; i < cnt; i++) begin
            seed = lfsr(seed);
            a = seed[16:0];
            write_burst(a, 1'b1);
            write_burst(a, 1'b0);
            read_burst(a, lat);
        end
    endtask

    // Whole run needs a few microseconds; this limit is far beyond it
    initial begin
        #100000;
        failures++;
        conclude();
    end

    // Bypass first, then lock, then bypass again after the DLL is switched off
    initial begin
        repeat (12) @(negedge clk_i);
        reset_i = 1'b0;
        repeat (6) @(posedge k_clk_i);
        check("locked_bypass", {35'h0, dll_locked_o}, 36'h0);
        run_bursts(3, 1);
        @(negedge clk_i);
        doff_n_i = 1'b1;
        for (n = 0; n < 200 && dll_locked_o !== 1'b1; n++) begin
            @(negedge clk_i);
        end
        check("lock_wait", {35'h0, n >= LOCK && n < 200}, 36'h1);
        repeat (8) @(posedge k_clk_i);
        run_bursts(6, 2);
        @(negedge clk_i);
        doff_n_i = 1'b0;
        repeat (16) @(negedge clk_i);
        check("locked_off", {35'h0, dll_locked_o}, 36'h0);
        repeat (8) @(posedge k_clk_i);
        run_bursts(2, 1);
        conclude();
    end
endmodule
`default_nettype wire

/* File: hdl/dbs_pkg.sv */
// Package for the burst-of-four DDR SRAM port: widths, burst layout,
// latency selection, crossing depth and the command carrier types.
// Assumes one link (input strobe pair) and one internal system clock.
package dbs_pkg;

    // Burst address width; each address holds a burst of four words
    localparam int DBS_ADDR_W = 17;
    // Default data width (wide organisation); narrow one is 18
    localparam int DBS_DATA_W = 36;
    localparam int DBS_DATA_NARROW_W = 18;
    // Bits covered by one byte-write select
    localparam int DBS_LANE_W = 9;
    // Beats per burst and width of the beat index
    localparam int DBS_BURST_LEN = 4;
    localparam int DBS_BEAT_W = 2;
    localparam logic [1:0] DBS_BEAT0 = 2'h0;
    localparam logic [1:0] DBS_BEAT1 = 2'h1;
    localparam logic [1:0] DBS_BEAT2 = 2'h2;
    localparam logic [1:0] DBS_BEAT3 = 2'h3;
    // Command pipeline depth in strobe cycles
    localparam int DBS_RD_DEPTH = 4;
    localparam int DBS_WR_DEPTH = 3;
    // Pipeline stage holding the first beat pair, DLL on and bypassed
    localparam logic [1:0] DBS_LAT_IDX_DLL = 2'h2;
    localparam logic [1:0] DBS_LAT_IDX_BYP = 2'h1;
    // Write pipeline stages that commit beats 0/1 and 2/3
    localparam int DBS_WR_COMMIT_A = 1;
    localparam int DBS_WR_COMMIT_B = 2;
    // Default lock wait in system clock cycles
    localparam int DBS_LOCK_CYCLES = 2048;
    // Highest strobe rate permitted with the DLL bypassed
    localparam int DBS_BYPASS_MAX_MHZ = 167;
    // Input synchroniser length
    localparam int DBS_SYNC_LEN = 3;

    // DLL control state
    typedef enum logic [1:0] {
        DBS_DLL_OFF = 2'b00,
        DBS_DLL_LOCKING = 2'b01,
        DBS_DLL_LOCKED = 2'b11
    } dbs_dll_e;

    // One captured command for a pipeline stage
    typedef struct packed {
        logic valid;
        logic [DBS_ADDR_W-1:0] addr;
    } dbs_cmd_s;

endpackage

/* File: hdl/dbs_sram_port.sv */
// Burst-of-four DDR SRAM port with separate read and write buses,
// echo strobes, output-valid flag and DLL-off handling.
// Assumes the host drives both input strobes from one source and
// keeps the burst spacing; doff_n_i is asynchronous to everything.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Commands on true edge, data on both
// - Echo strobes match read data edges
// - Echo strobes toggle even when bus idle
// - DLL-off low bypasses and clears lock
// - DLL-off high relocks after lock time
// - Bypass gives one-cycle latency, 167 MHz max; here first beat 1.5 cycles later, rate unchecked
// - Valid flag marks read data, echo aligned
// - Address registered only when selected
// - Write bus 18 or 36 bits
// - Read bus 18 or 36, reads only
// - Read data launched with echo strobes
// - Write select low starts write cycle
// - Read select low starts read cycle
// - Byte selects sampled with each beat
// - DLL mode first beat 2.5 cycles later
module dbs_sram_port
    import dbs_pkg::*;
#(
    parameter int DATA_W = DBS_DATA_W,
    parameter int LOCK_CYCLES = DBS_LOCK_CYCLES
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic k_clk_i,
    input wire logic kn_clk_i,
    input wire logic doff_n_i,
    input wire logic [DBS_ADDR_W-1:0] address_bus_i,
    input wire logic rd_sel_n_i,
    input wire logic wr_sel_n_i,
    input wire logic [DATA_W/DBS_LANE_W-1:0] byte_write_n_i,
    input wire logic [DATA_W-1:0] write_in_bus_i,
    output logic [DATA_W-1:0] read_out_bus_o,
    output logic read_out_oe_n_o,
    output logic output_valid_flag_o,
    output logic echo_strobe_true_o,
    output logic echo_strobe_comp_o,
    output logic dll_locked_o
);

    localparam int LANES = DATA_W / DBS_LANE_W;
    localparam int MEM_W = DBS_ADDR_W + DBS_BEAT_W;
    localparam int CNT_W = $clog2(LOCK_CYCLES + 1);
    localparam logic [CNT_W-1:0] LOCK_LAST = CNT_W'(LOCK_CYCLES - 1);

    // Word address of one beat within a burst
    function automatic logic [MEM_W-1:0] beat_addr(
        input logic [DBS_ADDR_W-1:0] addr,
        input logic [1:0] beat
    );
        beat_addr = {addr, beat};
    endfunction

    // Keep the old lane wherever its byte-write select is high
    function automatic logic [DATA_W-1:0] merge_lanes(
        input logic [DATA_W-1:0] old_word,
        input logic [DATA_W-1:0] new_word,
        input logic [LANES-1:0] bw_n
    );
        logic [DATA_W-1:0] res;
        res = old_word;
        for (int i = 0; i < LANES; i++) begin
            if (!bw_n[i]) begin
                res[i*DBS_LANE_W +: DBS_LANE_W] = new_word[i*DBS_LANE_W +: DBS_LANE_W];
            end
        end
        merge_lanes = res;
    endfunction

    // ---------------- System clock domain: DLL control ----------------

    logic [DBS_SYNC_LEN-1:0] doff_sync_q;
    logic doff_hi_q;
    dbs_dll_e dll_state_q;
    dbs_dll_e dll_state_d;
    logic [CNT_W-1:0] lock_cnt_q;

    // Pin synchroniser; only the last two stages are ever compared
    always_ff @(posedge clk_i) begin
        doff_sync_q <= {doff_sync_q[DBS_SYNC_LEN-2:0], doff_n_i};
    end

    // Filtered level: accept a change once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            doff_hi_q <= 1'b0;
        end else if (doff_sync_q[1] == doff_sync_q[2]) begin
            doff_hi_q <= doff_sync_q[2];
        end
    end

    // DLL state: low input forces bypass and forgets the lock
    always_comb begin
        dll_state_d = dll_state_q;
        case (dll_state_q)
            DBS_DLL_OFF: begin
                if (doff_hi_q) begin
                    dll_state_d = DBS_DLL_LOCKING;
                end
            end
            DBS_DLL_LOCKING: begin
                if (!doff_hi_q) begin
                    dll_state_d = DBS_DLL_OFF;
                end else if (lock_cnt_q == LOCK_LAST) begin
                    dll_state_d = DBS_DLL_LOCKED;
                end
            end
            DBS_DLL_LOCKED: begin
                if (!doff_hi_q) begin
                    dll_state_d = DBS_DLL_OFF;
                end
            end
            default: begin
                dll_state_d = DBS_DLL_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            dll_state_q <= DBS_DLL_OFF;
        end else begin
            dll_state_q <= dll_state_d;
        end
    end

    // Lock timer restarts from zero on every new attempt
    always_ff @(posedge clk_i) begin
        if (reset_i || dll_state_q != DBS_DLL_LOCKING) begin
            lock_cnt_q <= '0;
        end else begin
            lock_cnt_q <= lock_cnt_q + CNT_W'(1);
        end
    end

    // Status flag for the host side of the system
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            dll_locked_o <= 1'b0;
        end else begin
            dll_locked_o <= (dll_state_d == DBS_DLL_LOCKED);
        end
    end

    // ---------------- Link domain: strobe-clocked logic ----------------

    // Limitations a user of this port must keep in mind:
    // - The latency mode follows the lock level a few strobe edges later.
    //   It is not held off for reads in flight, so the host switches the
    //   DLL only while no read burst is pending.
    // - Nothing here measures the strobe rate. The bypass rate ceiling
    //   (DBS_BYPASS_MAX_MHZ) is the host's to respect.
    // - A read that overlaps a write to the same burst is not forwarded.
    //   It returns whatever words have been committed by then.
    // - The strobe-domain reset only takes effect while the strobes run,
    //   so the host keeps them toggling through reset.
    // - Output-clock inputs are not modelled. Read data always follows the
    //   echo strobes, which are the input strobes passed straight through.
    // - Commands of one kind closer than two strobe cycles are not refused.
    //   Overlapping bursts then mix their beats.

    logic [DBS_SYNC_LEN-1:0] krst_sync_q;
    logic k_rst_q;
    logic [DBS_SYNC_LEN-1:0] klock_sync_q;
    logic k_dll_on_q;
    logic [1:0] lat_idx;
    logic dll_locked_lvl_q;

    // Level view of the lock state, launched from a flop before crossing
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            dll_locked_lvl_q <= 1'b0;
        end else begin
            dll_locked_lvl_q <= (dll_state_q == DBS_DLL_LOCKED);
        end
    end

    // Reset and lock level both cross into the strobe domain
    always_ff @(posedge k_clk_i) begin
        krst_sync_q <= {krst_sync_q[DBS_SYNC_LEN-2:0], reset_i};
        klock_sync_q <= {klock_sync_q[DBS_SYNC_LEN-2:0], dll_locked_lvl_q};
    end

    always_ff @(posedge k_clk_i) begin
        if (krst_sync_q[1] == krst_sync_q[2]) begin
            k_rst_q <= krst_sync_q[2];
        end
        if (krst_sync_q[2]) begin
            k_dll_on_q <= 1'b0;
        end else if (klock_sync_q[1] == klock_sync_q[2]) begin
            k_dll_on_q <= klock_sync_q[2];
        end
    end

    // Bypass trims a whole cycle off the read path
    assign lat_idx = k_dll_on_q ? DBS_LAT_IDX_DLL : DBS_LAT_IDX_BYP;

    // Storage: one word per beat of every burst address
    logic [DATA_W-1:0] mem [0:(1<<MEM_W)-1];

    dbs_cmd_s rd_pipe_q [0:DBS_RD_DEPTH-1];
    dbs_cmd_s wr_pipe_q [0:DBS_WR_DEPTH-1];
    dbs_cmd_s rd_cmd_d;
    dbs_cmd_s wr_cmd_d;

    // Decode on the true strobe; a deselect loads nothing new
    always_comb begin
        rd_cmd_d = '0;
        wr_cmd_d = '0;
        if (!rd_sel_n_i) begin
            rd_cmd_d.valid = 1'b1;
            rd_cmd_d.addr = address_bus_i;
        end
        if (!wr_sel_n_i) begin
            wr_cmd_d.valid = 1'b1;
            wr_cmd_d.addr = address_bus_i;
        end
    end

    // Command pipelines shift every cycle, so a deselect never cuts a burst
    always_ff @(posedge k_clk_i) begin
        if (k_rst_q) begin
            for (int i = 0; i < DBS_RD_DEPTH; i++) begin
                rd_pipe_q[i] <= '0;
            end
            for (int i = 0; i < DBS_WR_DEPTH; i++) begin
                wr_pipe_q[i] <= '0;
            end
        end else begin
            rd_pipe_q[0] <= rd_cmd_d;
            wr_pipe_q[0] <= wr_cmd_d;
            for (int i = 1; i < DBS_RD_DEPTH; i++) begin
                rd_pipe_q[i] <= rd_pipe_q[i-1];
            end
            for (int i = 1; i < DBS_WR_DEPTH; i++) begin
                wr_pipe_q[i] <= wr_pipe_q[i-1];
            end
        end
    end

    // Write beat capture: even beats on the true edge, odd on the complement
    logic [DATA_W-1:0] wd_even_q;
    logic [DATA_W-1:0] wd_odd_q;
    logic [LANES-1:0] bw_even_q;
    logic [LANES-1:0] bw_odd_q;

    always_ff @(posedge k_clk_i) begin
        wd_even_q <= write_in_bus_i;
        bw_even_q <= byte_write_n_i;
    end

    always_ff @(posedge kn_clk_i) begin
        wd_odd_q <= write_in_bus_i;
        bw_odd_q <= byte_write_n_i;
    end

    // Commit a beat pair per cycle; one writer keeps the array single-driven
    always_ff @(posedge k_clk_i) begin
        if (!k_rst_q && wr_pipe_q[DBS_WR_COMMIT_A].valid) begin
            mem[beat_addr(wr_pipe_q[DBS_WR_COMMIT_A].addr, DBS_BEAT0)] <= merge_lanes(
                mem[beat_addr(wr_pipe_q[DBS_WR_COMMIT_A].addr, DBS_BEAT0)],
                wd_even_q, bw_even_q);
            mem[beat_addr(wr_pipe_q[DBS_WR_COMMIT_A].addr, DBS_BEAT1)] <= merge_lanes(
                mem[beat_addr(wr_pipe_q[DBS_WR_COMMIT_A].addr, DBS_BEAT1)],
                wd_odd_q, bw_odd_q);
        end
        if (!k_rst_q && wr_pipe_q[DBS_WR_COMMIT_B].valid) begin
            mem[beat_addr(wr_pipe_q[DBS_WR_COMMIT_B].addr, DBS_BEAT2)] <= merge_lanes(
                mem[beat_addr(wr_pipe_q[DBS_WR_COMMIT_B].addr, DBS_BEAT2)],
                wd_even_q, bw_even_q);
            mem[beat_addr(wr_pipe_q[DBS_WR_COMMIT_B].addr, DBS_BEAT3)] <= merge_lanes(
                mem[beat_addr(wr_pipe_q[DBS_WR_COMMIT_B].addr, DBS_BEAT3)],
                wd_odd_q, bw_odd_q);
        end
    end

    // Read launch registers, one per strobe edge
    logic [DATA_W-1:0] q_true_q;
    logic [DATA_W-1:0] q_comp_q;
    logic v_true_q;
    logic v_comp_q;
    dbs_cmd_s rd_first;
    dbs_cmd_s rd_second;

    // Stage lat_idx is the burst's first half, the next stage its second
    assign rd_first = rd_pipe_q[lat_idx];
    assign rd_second = rd_pipe_q[lat_idx + 2'h1];

    // Complement edge launches beats 0 and 2
    always_ff @(posedge kn_clk_i) begin
        if (k_rst_q) begin
            q_comp_q <= '0;
            v_comp_q <= 1'b0;
        end else if (rd_first.valid) begin
            q_comp_q <= mem[beat_addr(rd_first.addr, DBS_BEAT0)];
            v_comp_q <= 1'b1;
        end else if (rd_second.valid) begin
            q_comp_q <= mem[beat_addr(rd_second.addr, DBS_BEAT2)];
            v_comp_q <= 1'b1;
        end else begin
            q_comp_q <= '0;
            v_comp_q <= 1'b0;
        end
    end

    // True edge launches beats 1 and 3
    always_ff @(posedge k_clk_i) begin
        if (k_rst_q) begin
            q_true_q <= '0;
            v_true_q <= 1'b0;
        end else if (rd_first.valid) begin
            q_true_q <= mem[beat_addr(rd_first.addr, DBS_BEAT1)];
            v_true_q <= 1'b1;
        end else if (rd_second.valid) begin
            q_true_q <= mem[beat_addr(rd_second.addr, DBS_BEAT3)];
            v_true_q <= 1'b1;
        end else begin
            q_true_q <= '0;
            v_true_q <= 1'b0;
        end
    end

    // DDR output stage: the strobe level picks the register launched last.
    // A mux on the strobe is the only way both edges reach one pin, so the
    // data, valid and output-enable paths share it and stay edge matched to the echo strobes.
    assign read_out_bus_o = k_clk_i ? q_true_q : q_comp_q;
    assign output_valid_flag_o = k_clk_i ? v_true_q : v_comp_q;
    assign read_out_oe_n_o = k_clk_i ? !v_true_q : !v_comp_q;
    // Echo strobes free-run from the input pair, also between reads
    assign echo_strobe_true_o = k_clk_i;
    assign echo_strobe_comp_o = kn_clk_i;

endmodule

`default_nettype wire
